// ==== hdl/msfr_top.sv ====
// Purpose: Special function register bank of a small 8-bit controller.
// Assumes: One clock, synchronous reset, APB register access.
// Notes:   Port pins are synchronised; the core supplies ALU requests.
`timescale 1ns/1ns
`default_nettype none
`include "msfr_params.svh"

module msfr_top (
  input  wire logic                   CLK,           // Core clock.
  input  wire logic                   RST,           // Synchronous reset, high.
  input  wire logic                   PSEL,          // APB select.
  input  wire logic                   PENABLE,       // APB enable.
  input  wire logic                   PWRITE,        // APB direction.
  input  wire logic [7:0]             PADDR,         // APB byte address.
  input  wire logic [31:0]            PWDATA,        // APB write data.
  output logic      [31:0]            PRDATA,        // APB read data.
  output logic                        PREADY,        // APB ready.
  output logic                        PSLVERR,       // APB error.
  input  wire msfr_pkg::msfr_alu_req_s ALU_REQ,      // ALU request.
  output logic      [7:0]             ALU_RESULT,    // Last ALU result.
  input  wire msfr_pkg::msfr_evt_s    CORE_EVT,      // Core events.
  input  wire logic                   PCL_WR,        // PC low byte written.
  input  wire logic [7:0]             PCL_DATA,      // New PC low byte.
  output logic                        PC_LOAD,       // PC load pulse.
  output logic      [9:0]             PC_TARGET,     // PC load value.
  input  wire logic [3:0]             DIR_A,         // Port A direction, 1 input.
  input  wire logic [7:0]             DIR_B,         // Port B direction, 1 input.
  input  wire logic [3:0]             PA_IN,         // Port A pin levels.
  output logic      [3:0]             PA_OUT,        // Port A drive value.
  output logic      [3:0]             PA_OE,         // Port A drive enable.
  input  wire logic [7:0]             PB_IN,         // Port B pin levels.
  output logic      [7:0]             PB_OUT,        // Port B drive value.
  output logic      [7:0]             PB_OE,         // Port B drive enable.
  output logic      [3:0]             PULLDOWN_A,    // Port A pull-down on.
  output logic      [2:0]             PULLDOWN_B,    // Port B pull-down on.
  output logic                        WDT_ENABLE,    // Watchdog enable.
  output logic                        LVD_ENABLE,    // Low-voltage detect enable.
  output logic                        EXT_INT,       // External interrupt level.
  output logic                        CHANGE_EVENT,  // Port B change pulse.
  output logic      [5:0]             INDIRECT_ADDR  // Indirect address.
);
  import msfr_pkg::*;

  // Stored register fields.
  logic       wake_cause_reg;         // Wake-up cause bit.
  logic [1:0] spare_status_bits_reg;  // General status storage.
  logic       watchdog_timeout_flag_reg;
  logic       power_down_flag_reg;
  logic       zero_flag_reg;          // Zero flag.
  logic       half_carry_flag_reg;    // Half carry flag.
  logic       carry_flag_reg;         // Carry flag.
  logic [5:0] indirect_pointer_reg;   // Pointer bits 5..0.
  logic [7:0] port_a_data_reg;        // Port A latch and storage.
  logic [7:0] port_b_data_reg;        // Port B latch.
  logic       watchdog_enable_reg;    // Watchdog enable.
  logic       interrupt_pin_select_reg;
  logic       low_voltage_detect_enable_reg;
  logic [7:0] change_wake_bits_reg;   // Per-pin change enables.
  logic [1:0] pc_high_buffer_reg;     // PC bits 9..8 source.
  logic [7:0] pull_down_control_reg;  // Active-low pull-downs.
  logic [7:0] open_drain_bits_reg;    // Open-drain enables.

  // APB decode.
  logic       setup_phase;            // First cycle of a transfer.
  logic       wr_hit;                 // Write takes effect now.
  logic [5:0] idx;                    // Register index.
  logic       aligned;                // Low address bits zero.
  logic [7:0] rd_byte;                // Read mux output.
  logic       rd_ok;                  // Address is mapped.
  logic       err_reg;                // Latched error answer.

  // Pin synchronisers and stable levels.
  logic [7:0] pb_s1_reg;              // Port B first stage.
  logic [7:0] pb_s2_reg;              // Port B second stage.
  logic [7:0] pb_s3_reg;              // Port B third stage.
  logic [7:0] pb_stable_reg;          // Port B accepted level.
  logic [7:0] pb_stable_next;         // Port B next accepted level.
  logic [3:0] pa_s1_reg;              // Port A first stage.
  logic [3:0] pa_s2_reg;              // Port A second stage.
  logic [3:0] pa_s3_reg;              // Port A third stage.
  logic [3:0] pa_stable_reg;          // Port A accepted level.
  logic [7:0] change_mask;            // Pins allowed to report change.

  // ALU flag results.
  logic [8:0] sum9;                   // Full sum with carry out.
  logic [4:0] sum5;                   // Low nibble sum.
  logic [7:0] alu_res;                // Operation result.
  logic       alu_c;                  // Carry result.
  logic       alu_dc;                 // Half carry result.
  logic       alu_z;                  // Zero result.
  logic       aff_zdc;                // Op touches zero flag.
  logic       aff_c;                  // Op touches carry.
  logic       aff_dc;                 // Op touches half carry.

  assign setup_phase = PSEL && !PENABLE;
  assign wr_hit      = PSEL && PENABLE && PWRITE && PREADY;
  assign idx         = PADDR[7:2];
  assign aligned     = (PADDR[1:0] == 2'h0);
  assign PREADY      = 1'b1;
  assign PSLVERR     = PSEL && PENABLE && err_reg;

  // Read mux; unimplemented bits show their fixed value.
  always_comb begin
    rd_byte = 8'h00;
    rd_ok   = aligned;
    unique case (idx)
      `MSFR_IDX_STATUS: begin
        rd_byte = {wake_cause_reg, spare_status_bits_reg,
                   watchdog_timeout_flag_reg, power_down_flag_reg,
                   zero_flag_reg, half_carry_flag_reg, carry_flag_reg};
      end
      `MSFR_IDX_FSR: begin
        rd_byte = {`MSFR_FSR_FILL, indirect_pointer_reg};
      end
      `MSFR_IDX_PORT_A_DATA: begin
        rd_byte = {port_a_data_reg[7:4], pa_stable_reg};
      end
      `MSFR_IDX_PORT_B_DATA: begin
        rd_byte = pb_stable_reg;
      end
      `MSFR_IDX_POWER: begin
        rd_byte = {watchdog_enable_reg, interrupt_pin_select_reg,
                   low_voltage_detect_enable_reg, `MSFR_POWER_FILL};
      end
      `MSFR_IDX_WAKE: begin
        rd_byte = change_wake_bits_reg;
      end
      `MSFR_IDX_PC_HIGH_BUFFER: begin
        rd_byte = {`MSFR_PC_HIGH_BUFFER_FILL, pc_high_buffer_reg};
      end
      `MSFR_IDX_PDOWN: begin
        rd_byte = pull_down_control_reg;
      end
      `MSFR_IDX_ODRAIN: begin
        rd_byte = open_drain_bits_reg;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA  <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (setup_phase) begin
      PRDATA  <= {24'h00_0000, rd_ok ? rd_byte : 8'h00};
      err_reg <= !rd_ok;
    end
  end

  // ALU: subtract adds the complement; rotates go through carry.
  always_comb begin
    sum9    = 9'h000;
    sum5    = 5'h00;
    alu_res = ALU_REQ.a;
    alu_c   = carry_flag_reg;
    aff_zdc = 1'b0;
    aff_c   = 1'b0;
    aff_dc  = 1'b0;
    unique case (ALU_REQ.op)
      MSFR_OP_ADD: begin
        sum9    = {1'b0, ALU_REQ.a} + {1'b0, ALU_REQ.b};
        sum5    = {1'b0, ALU_REQ.a[3:0]} + {1'b0, ALU_REQ.b[3:0]};
        alu_res = sum9[7:0];
        alu_c   = sum9[8];
        aff_zdc = 1'b1;
        aff_c   = 1'b1;
        aff_dc  = 1'b1;
      end
      MSFR_OP_SUB: begin
        sum9    = {1'b0, ALU_REQ.a} + {1'b0, ~ALU_REQ.b} + 9'h001;
        sum5    = {1'b0, ALU_REQ.a[3:0]} + {1'b0, ~ALU_REQ.b[3:0]} + 5'h01;
        alu_res = sum9[7:0];
        alu_c   = sum9[8];
        aff_zdc = 1'b1;
        aff_c   = 1'b1;
        aff_dc  = 1'b1;
      end
      MSFR_OP_ROR: begin
        alu_res = {carry_flag_reg, ALU_REQ.a[7:1]};
        alu_c   = ALU_REQ.a[0];
        aff_c   = 1'b1;
      end
      MSFR_OP_ROL: begin
        alu_res = {ALU_REQ.a[6:0], carry_flag_reg};
        alu_c   = ALU_REQ.a[7];
        aff_c   = 1'b1;
      end
      MSFR_OP_LOGIC: begin
        aff_zdc = 1'b1;
      end
      default: begin
        alu_res = ALU_REQ.a;
      end
    endcase
    alu_dc = sum5[4];
    alu_z  = (alu_res == 8'h00);
  end

  // Last ALU result for the core.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ALU_RESULT <= 8'h00;
    end else if (ALU_REQ.valid) begin
      ALU_RESULT <= alu_res;
    end
  end

  // Arithmetic flags; an ALU update wins over a bus write.
  always_ff @(posedge CLK) begin
    if (RST) begin
      zero_flag_reg       <= 1'b0;
      half_carry_flag_reg <= 1'b0;
      carry_flag_reg      <= 1'b0;
    end else if (ALU_REQ.valid && (aff_zdc || aff_c)) begin
      // All written flag bits are dropped; flags the op does not touch keep their value.
      if (aff_zdc) begin
        zero_flag_reg <= alu_z;
      end
      if (aff_dc) begin
        half_carry_flag_reg <= alu_dc;
      end
      if (aff_c) begin
        carry_flag_reg <= alu_c;
      end
    end else if (wr_hit && idx == `MSFR_IDX_STATUS) begin
      zero_flag_reg       <= PWDATA[2];
      half_carry_flag_reg <= PWDATA[1];
      carry_flag_reg      <= PWDATA[0];
    end
  end

  // Spare status bits take bus writes and status-destination results.
  always_ff @(posedge CLK) begin
    if (RST) begin
      spare_status_bits_reg <= 2'h0;
    end else if (ALU_REQ.valid && ALU_REQ.dest_status) begin
      spare_status_bits_reg <= alu_res[6:5];
    end else if (wr_hit && idx == `MSFR_IDX_STATUS) begin
      spare_status_bits_reg <= PWDATA[6:5];
    end
  end

  // Reset flags change only on hardware events, never on writes.
  always_ff @(posedge CLK) begin
    if (RST) begin
      power_down_flag_reg       <= 1'b1;
      watchdog_timeout_flag_reg <= 1'b1;
    end else begin
      if (CORE_EVT.watchdog_clear_instr) begin
        power_down_flag_reg <= 1'b1;
      end else if (CORE_EVT.sleep_instr) begin
        power_down_flag_reg <= 1'b0;
      end
      if (CORE_EVT.watchdog_clear_instr || CORE_EVT.sleep_instr) begin
        watchdog_timeout_flag_reg <= 1'b1;
      end else if (CORE_EVT.wdt_overflow) begin
        watchdog_timeout_flag_reg <= 1'b0;
      end
    end
  end

  // Wake cause is set only by a change wake; every reset clears it.
  always_ff @(posedge CLK) begin
    if (RST) begin
      wake_cause_reg <= 1'b0;
    end else if (CORE_EVT.change_wake) begin
      wake_cause_reg <= 1'b1;
    end
  end

  // Indirect pointer keeps six bits only.
  always_ff @(posedge CLK) begin
    if (RST) begin
      indirect_pointer_reg <= `MSFR_RST_FSR;
    end else if (wr_hit && idx == `MSFR_IDX_FSR) begin
      indirect_pointer_reg <= PWDATA[5:0];
    end
  end
  assign INDIRECT_ADDR = indirect_pointer_reg;

  // Port data latches; only port A bits 7..4 of a write reach the read path.
  always_ff @(posedge CLK) begin
    if (RST) begin
      port_a_data_reg <= `MSFR_RST_PORT_A_DATA;
      port_b_data_reg <= `MSFR_RST_PORT_B_DATA;
    end else if (wr_hit) begin
      if (idx == `MSFR_IDX_PORT_A_DATA) begin
        port_a_data_reg <= PWDATA[7:0];
      end
      if (idx == `MSFR_IDX_PORT_B_DATA) begin
        port_b_data_reg <= PWDATA[7:0];
      end
    end
  end

  // Power control: only the three enables are stored.
  always_ff @(posedge CLK) begin
    if (RST) begin
      watchdog_enable_reg           <= 1'b0;
      interrupt_pin_select_reg      <= 1'b0;
      low_voltage_detect_enable_reg <= 1'b0;
    end else if (wr_hit && idx == `MSFR_IDX_POWER) begin
      watchdog_enable_reg           <= PWDATA[7];
      interrupt_pin_select_reg      <= PWDATA[6];
      low_voltage_detect_enable_reg <= PWDATA[5];
    end
  end
  assign WDT_ENABLE = watchdog_enable_reg;
  assign LVD_ENABLE = low_voltage_detect_enable_reg;

  // Change enables, pull-downs and open-drain controls.
  always_ff @(posedge CLK) begin
    if (RST) begin
      change_wake_bits_reg  <= `MSFR_RST_WAKE;
      pull_down_control_reg <= `MSFR_RST_PDOWN;
      open_drain_bits_reg   <= `MSFR_RST_ODRAIN;
    end else if (wr_hit) begin
      if (idx == `MSFR_IDX_WAKE) begin
        change_wake_bits_reg <= PWDATA[7:0];
      end
      if (idx == `MSFR_IDX_PDOWN) begin
        pull_down_control_reg <= PWDATA[7:0];
      end
      if (idx == `MSFR_IDX_ODRAIN) begin
        open_drain_bits_reg <= PWDATA[7:0];
      end
    end
  end

  // High buffer: bus writes only; the PC never copies back into it.
  always_ff @(posedge CLK) begin
    if (RST) begin
      pc_high_buffer_reg <= `MSFR_RST_PC_HIGH_BUFFER;
    end else if (wr_hit && idx == `MSFR_IDX_PC_HIGH_BUFFER) begin
      pc_high_buffer_reg <= PWDATA[1:0];
    end
  end

  // Only a low-byte write loads the PC with the buffered top bits.
  always_ff @(posedge CLK) begin
    if (RST) begin
      PC_LOAD   <= 1'b0;
      PC_TARGET <= 10'h000;
    end else begin
      PC_LOAD <= PCL_WR;
      if (PCL_WR) begin
        PC_TARGET <= {pc_high_buffer_reg, PCL_DATA};
      end
    end
  end

  // Three-stage pin synchronisers; a level counts once stages 2 and 3 agree.
  always_ff @(posedge CLK) begin
    if (RST) begin
      pb_s1_reg     <= 8'h00;
      pb_s2_reg     <= 8'h00;
      pb_s3_reg     <= 8'h00;
      pb_stable_reg <= 8'h00;
      pa_s1_reg     <= 4'h0;
      pa_s2_reg     <= 4'h0;
      pa_s3_reg     <= 4'h0;
      pa_stable_reg <= 4'h0;
    end else begin
      pb_s1_reg     <= PB_IN;
      pb_s2_reg     <= pb_s1_reg;
      pb_s3_reg     <= pb_s2_reg;
      pb_stable_reg <= pb_stable_next;
      pa_s1_reg     <= PA_IN;
      pa_s2_reg     <= pa_s1_reg;
      pa_s3_reg     <= pa_s2_reg;
      pa_stable_reg <= (pa_s2_reg & pa_s3_reg) | (pa_stable_reg & (pa_s2_reg ^ pa_s3_reg));
    end
  end
  assign pb_stable_next = (pb_s2_reg & pb_s3_reg) | (pb_stable_reg & (pb_s2_reg ^ pb_s3_reg));

  // Pin 0 reports no change while it serves the external interrupt.
  assign change_mask = change_wake_bits_reg & {7'h7f, !interrupt_pin_select_reg};

  // Change pulse on the same edge as an enabled pin's accepted level moves.
  always_ff @(posedge CLK) begin
    if (RST) begin
      CHANGE_EVENT <= 1'b0;
    end else begin
      CHANGE_EVENT <= |((pb_stable_next ^ pb_stable_reg) & change_mask);
    end
  end

  // Interrupt path from pin 0 is open only when selected.
  assign EXT_INT = interrupt_pin_select_reg && pb_stable_reg[0];

  // Port A push-pull drivers and active-low pull-downs of ports A and B.
  assign PA_OUT     = port_a_data_reg[3:0];
  assign PA_OE      = ~DIR_A;
  assign PULLDOWN_A = ~pull_down_control_reg[3:0] & DIR_A;
  assign PULLDOWN_B = ~pull_down_control_reg[6:4] & DIR_B[2:0];

  // Port B drivers; open-drain pins only pull low.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pb
      if (gi == 3) begin : g_od_only
        // Pin 3 is open-drain while its direction bit is 0.
        assign PB_OUT[gi] = 1'b0;
        assign PB_OE[gi]  = !DIR_B[gi] && !port_b_data_reg[gi];
      end else begin : g_normal
        // Open-drain bit set: drive low only, else push-pull.
        assign PB_OUT[gi] = port_b_data_reg[gi] && !open_drain_bits_reg[gi];
        assign PB_OE[gi]  = !DIR_B[gi] &&
                            !(open_drain_bits_reg[gi] && port_b_data_reg[gi]);
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ==== inc/msfr_params.svh ====
// Purpose: Offsets, fixed read fills and reset values of the register bank.
// Assumes: Byte address on APB is four times the register index.
// Notes:   Definitions only.
`ifndef MSFR_PARAMS_SVH
`define MSFR_PARAMS_SVH

// Register indices; byte address is index times four.
`define MSFR_IDX_STATUS  6'h03
`define MSFR_IDX_FSR     6'h04
`define MSFR_IDX_PORT_A_DATA   6'h05
`define MSFR_IDX_PORT_B_DATA   6'h06
`define MSFR_IDX_POWER   6'h08
`define MSFR_IDX_WAKE    6'h09
`define MSFR_IDX_PC_HIGH_BUFFER  6'h0a
`define MSFR_IDX_PDOWN   6'h0b
`define MSFR_IDX_ODRAIN  6'h0c

// Fixed read values of unimplemented bits.
`define MSFR_FSR_FILL    2'h3
`define MSFR_POWER_FILL  5'h1f
`define MSFR_PC_HIGH_BUFFER_FILL 6'h00

// Reset values of the stored fields.
`define MSFR_RST_PORT_A_DATA   8'h00
`define MSFR_RST_PORT_B_DATA   8'h00
`define MSFR_RST_FSR     6'h00
`define MSFR_RST_WAKE    8'h00
`define MSFR_RST_PDOWN   8'hff
`define MSFR_RST_ODRAIN  8'h00
`define MSFR_RST_PC_HIGH_BUFFER  2'h0

// Pin synchroniser depth.
`define MSFR_SYNC_DEPTH  3

`endif

// ==== inc/msfr_pkg.sv ====
// Purpose: Types shared by the register bank and its users.
// Assumes: The core presents one ALU request and one event set per clock.
// Notes:   Constants live in msfr_params.svh.
package msfr_pkg;

  // Flag-affecting operation kinds.
  typedef enum logic [2:0] {
    MSFR_OP_ADD,
    MSFR_OP_SUB,
    MSFR_OP_ROR,
    MSFR_OP_ROL,
    MSFR_OP_LOGIC
  } msfr_alu_op_e;

  // One ALU request from the core.
  typedef struct packed {
    logic         valid;       // Request present this cycle.
    msfr_alu_op_e op;          // Operation kind.
    logic [7:0]   a;           // First operand, rotate source or logic result.
    logic [7:0]   b;           // Second operand.
    logic         dest_status; // Result goes to the status register.
  } msfr_alu_req_s;

  // Core and system events, one-cycle pulses.
  typedef struct packed {
    logic watchdog_clear_instr; // Watchdog clear executed.
    logic sleep_instr;          // Sleep executed.
    logic wdt_overflow;         // Watchdog timer overflowed.
    logic change_wake;          // Wake from sleep by port B change.
  } msfr_evt_s;

endpackage

// ==== sim/msfr_core_model.sv ====
// Purpose: Instruction core model that feeds ALU requests and events.
// Assumes: Each request stands for one clock and is taken at the next edge.
// Notes:   Signals change by non-blocking assignment after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module msfr_core_model (
  input  wire logic              clk,
  output var msfr_pkg::msfr_alu_req_s alu_req,
  output var msfr_pkg::msfr_evt_s     core_evt,
  output var logic               pcl_wr,
  output var logic [7:0]         pcl_data
);
  import msfr_pkg::*;
  // Idle core at time zero.
  initial begin
    alu_req = '0;
    core_evt = '0;
    pcl_wr = 1'b0;
    pcl_data = 8'h00;
  end
  // One flag-affecting operation for a single cycle.
  task automatic alu(input msfr_alu_op_e op, input logic [7:0] a, b, input logic dst);
    @(posedge clk);
    alu_req <= '{1'b1, op, a, b, dst};
    @(posedge clk);
    alu_req.valid <= 1'b0;
  endtask
  // One-cycle event pulses, fields in struct order.
  task automatic evt(input logic [3:0] e);
    @(posedge clk);
    core_evt <= e;
    @(posedge clk);
    core_evt <= '0;
  endtask
  // A write of the program counter low byte.
  task automatic pc_low_byte(input logic [7:0] d);
    @(posedge clk);
    pcl_wr <= 1'b1;
    pcl_data <= d;
    @(posedge clk);
    pcl_wr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== sim/msfr_top_monitor.sv ====
// Purpose: Concurrent checks on the ports of the register bank.
// Assumes: One clock, synchronous active-high reset, zero-wait APB.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ns
`default_nettype none
module msfr_monitor (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PSLVERR,
  input wire logic        PCL_WR,
  input wire logic        PC_LOAD,
  input wire logic [3:0]  DIR_A,
  input wire logic [7:0]  DIR_B,
  input wire logic [7:0]  PB_OUT,
  input wire logic [7:0]  PB_OE,
  input wire logic [3:0]  PULLDOWN_A,
  input wire logic        WDT_ENABLE,
  input wire logic [5:0]  INDIRECT_ADDR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // High on the edge that completes a register write.
  logic wr_done;
  assign wr_done = PSEL && PENABLE && PWRITE;
  a_pc_load: assert property (PCL_WR |=> PC_LOAD)
    else $error("pc load pulse missing");
  a_pc_quiet: assert property (!PCL_WR |=> !PC_LOAD)
    else $error("pc load without low byte write");
  a_pin3_input: assert property (DIR_B[3] |-> !PB_OE[3])
    else $error("pin b3 driven while input");
  a_pin3_drain: assert property (PB_OE[3] |-> !PB_OUT[3])
    else $error("pin b3 drives high");
  a_drive_dir: assert property ((PB_OE & DIR_B) == 8'h00)
    else $error("port b driven while input");
  a_pull_off: assert property ((PULLDOWN_A & ~DIR_A) == 4'h0)
    else $error("pull-down on an output pin");
  a_wdt_write: assert property (wr_done && PADDR == 8'h20 |=> WDT_ENABLE == $past(PWDATA[7]))
    else $error("watchdog enable not updated");
  a_ptr_write: assert property (wr_done && PADDR == 8'h10 |=> INDIRECT_ADDR == $past(PWDATA[5:0]))
    else $error("indirect address not updated");
  a_bad_addr: assert property (PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("unaligned access not refused");
  // Main scenarios reached.
  c_pc_load: cover property (PC_LOAD);
  c_wdt_on: cover property (WDT_ENABLE);
  c_refused: cover property (PSLVERR);
endmodule
bind msfr_top msfr_monitor u_mon (.*);
`default_nettype wire

// ==== sim/msfr_top_tb.sv ====
// Purpose: Self-checking bench for the register bank.
// Assumes: Zero-wait APB, byte address is four times the index.
// Notes:   Pins and directions are driven here, core traffic by the model.
`timescale 1ns/1ns
`default_nettype none
module msfr_top_tb;
  import msfr_pkg::*;
  logic          CLK, RST, PSEL, PENABLE, PWRITE, PCL_WR, PREADY, PSLVERR, PC_LOAD;
  logic          WDT_ENABLE, LVD_ENABLE, EXT_INT, CHANGE_EVENT, err;
  logic [7:0]    PADDR, PCL_DATA, ALU_RESULT, DIR_B, PB_IN, PB_OUT, PB_OE;
  logic [31:0]   PWDATA, PRDATA, rd;
  logic [3:0]    DIR_A, PA_IN, PA_OUT, PA_OE, PULLDOWN_A;
  logic [2:0]    PULLDOWN_B;
  logic [9:0]    PC_TARGET;
  logic [5:0]    INDIRECT_ADDR;
  msfr_alu_req_s ALU_REQ;
  msfr_evt_s     CORE_EVT;
  int            error_cnt = 0;
  int            num_checks = 0;
  int            cyc = 0;
  msfr_top dut (.*);
  msfr_core_model core (.clk(CLK), .alu_req(ALU_REQ), .core_evt(CORE_EVT),
                        .pcl_wr(PCL_WR), .pcl_data(PCL_DATA));
  always #10 CLK = ~CLK;
  // Cuts a hang short as a mismatch.
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic wr, input logic [7:0] a, d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= 32'(d);
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rck(input logic [7:0] a, exp);
    apb(1'b0, a, 8'h00);
    chk(rd, 32'(exp));
  endtask
  task automatic alu_chk(input msfr_alu_op_e op, input logic [7:0] a, b, st, res);
    core.alu(op, a, b, 1'b0);
    rck(8'h0C, st);
    chk(32'(ALU_RESULT), 32'(res));
  endtask
  // Checks whether any change pulse comes within ten cycles.
  task automatic wait_evt(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (10) begin
      @(posedge CLK);
      if (CHANGE_EVENT === 1'b1) seen = 1'b1;
    end
    chk(32'(seen), 32'(exp));
  endtask
  initial begin
    {CLK, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PA_IN, PB_IN} = '0;
    RST = 1'b1;
    DIR_A = 4'hF;
    DIR_B = 8'hFF;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    rck(8'h0C, 8'h18);
    rck(8'h10, 8'hC0);
    rck(8'h20, 8'h1F);
    apb(1'b1, 8'h0C, 8'hFF);
    rck(8'h0C, 8'h7F);
    apb(1'b1, 8'h0C, 8'h00);
    rck(8'h0C, 8'h18);
    alu_chk(MSFR_OP_ADD, 8'h0F, 8'h01, 8'h1A, 8'h10);
    alu_chk(MSFR_OP_ADD, 8'hFF, 8'h01, 8'h1F, 8'h00);
    alu_chk(MSFR_OP_SUB, 8'h10, 8'h01, 8'h19, 8'h0F);
    alu_chk(MSFR_OP_SUB, 8'h05, 8'h05, 8'h1F, 8'h00);
    alu_chk(MSFR_OP_SUB, 8'h00, 8'h01, 8'h18, 8'hFF);
    alu_chk(MSFR_OP_ROR, 8'h03, 8'h00, 8'h19, 8'h01);
    alu_chk(MSFR_OP_ROL, 8'h7F, 8'h00, 8'h18, 8'hFF);
    alu_chk(MSFR_OP_LOGIC, 8'h00, 8'h00, 8'h1C, 8'h00);
    core.alu(MSFR_OP_ADD, 8'hFF, 8'h01, 1'b1);
    rck(8'h0C, 8'h1F);
    core.alu(MSFR_OP_LOGIC, 8'h60, 8'h00, 1'b1);
    rck(8'h0C, 8'h7B);
    core.evt(4'b0010);
    rck(8'h0C, 8'h6B);
    core.evt(4'b0100);
    rck(8'h0C, 8'h73);
    core.evt(4'b1000);
    rck(8'h0C, 8'h7B);
    core.evt(4'b0001);
    apb(1'b1, 8'h0C, 8'h00);
    rck(8'h0C, 8'h98);
    apb(1'b1, 8'h10, 8'h15);
    rck(8'h10, 8'hD5);
    apb(1'b1, 8'h20, 8'hBF);
    rck(8'h20, 8'hBF);
    chk(32'({WDT_ENABLE, LVD_ENABLE}), 32'h0000_0003);
    apb(1'b1, 8'h20, 8'h00);
    apb(1'b1, 8'h28, 8'hFE);
    rck(8'h28, 8'h02);
    core.pc_low_byte(8'h34);
    @(negedge CLK);
    chk(32'(PC_TARGET), 32'h0000_0234);
    rck(8'h28, 8'h02);
    PA_IN <= 4'h3;
    PB_IN <= 8'h5A;
    repeat (4) @(posedge CLK);
    apb(1'b1, 8'h14, 8'hA5);
    rck(8'h14, 8'hA3);
    chk(32'(PA_OUT), 32'h0000_0005);
    apb(1'b1, 8'h18, 8'hFF);
    rck(8'h18, 8'h5A);
    DIR_B <= 8'h00;
    apb(1'b1, 8'h30, 8'h00);
    @(negedge CLK);
    chk(32'({PB_OE, PB_OUT}), 32'h0000_F7F7);
    apb(1'b1, 8'h30, 8'hFF);
    rck(8'h30, 8'hFF);
    chk(32'({PB_OE, PB_OUT}), 32'h0000_0000);
    apb(1'b1, 8'h18, 8'h00);
    @(negedge CLK);
    chk(32'({PB_OE, PB_OUT}), 32'h0000_FF00);
    // Directions change on a rising edge; two port A pins become outputs.
    @(posedge CLK);
    DIR_A <= 4'h3;
    DIR_B <= 8'hFF;
    apb(1'b1, 8'h2C, 8'hA5);
    rck(8'h2C, 8'hA5);
    chk(32'({PA_OE, PULLDOWN_B, PULLDOWN_A}), 32'h0000_0652);
    apb(1'b1, 8'h24, 8'h01);
    PB_IN <= 8'h5B;
    wait_evt(1'b1);
    PB_IN <= 8'h59;
    wait_evt(1'b0);
    apb(1'b1, 8'h20, 8'h40);
    PB_IN <= 8'h58;
    wait_evt(1'b0);
    chk(32'(EXT_INT), 32'h0000_0000);
    PB_IN <= 8'h59;
    repeat (5) @(posedge CLK);
    chk(32'(EXT_INT), 32'h0000_0001);
    rck(8'h18, 8'h59);
    apb(1'b1, 8'h20, 8'h00);
    @(negedge CLK);
    chk(32'(EXT_INT), 32'h0000_0000);
    apb(1'b0, 8'h1C, 8'h00);
    chk({rd[30:0], err}, 32'h0000_0001);
    // An unaligned read of a mapped word is refused with zero data.
    apb(1'b0, 8'h0D, 8'h00);
    chk({rd[30:0], err}, 32'h0000_0001);
    complete_run();
  end
endmodule
`default_nettype wire
